// File: eivp_top.sv
// What this block does
// - select bit picks application or boot vectors
// - boot base comes from boot size fuses
// - 2K boot: reset 0x3C00, vectors from 0x3C02
// - enable self-clears after four cycles or select
// - block interrupts during the change sequence
// - global enable flag is never touched
// - boot vectors plus app lock mute app code
// - app vectors plus boot lock mute boot code
// - pins interrupt even when driven as outputs
// - three pin-change groups with per-pin masks
// - pin-change detection serves wake from sleep
// - low level keeps requesting while held
// - external pin detection serves wake from sleep
// - wake level must outlast start-up for interrupt
// - second pin needs global and own enable
// - two-bit sense: low, change, fall, rise
// - pin sampled first; longer pulses always caught
// - sense register upper nibble reads zero
// - first pin uses the same sense encoding
// - edge flag set, cleared by entry or one
// - each pin also needs its mask bit
`timescale 1ns/1ps
module eivp_top
    import eivp_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    input wire logic I_GLOBAL_IE,
    input wire logic I_INSTR_DONE,
    input wire logic I_EXEC_IN_BOOT,
    input wire logic I_IRQ_ACK,
    input wire logic [2:0] I_ACK_INDEX,
    input wire logic [1:0] I_BOOT_SIZE_FUSES,
    input wire logic I_BOOT_RESET_FUSE,
    input wire logic I_APP_SIDE_BOOT_LOCK,
    input wire logic I_BOOT_SIDE_BOOT_LOCK,
    input wire logic I_EXT_IRQ_PIN_A,
    input wire logic I_EXT_IRQ_PIN_B,
    input wire logic [23:0] I_PIN_CHANGE_INPUTS,
    output logic [4:0] O_IRQ_REQ,
    output logic [15:0] O_IRQ_VECTOR,
    output logic [15:0] O_VECTOR_BASE,
    output logic [15:0] O_RESET_ADDR,
    output logic O_IRQ_BLOCKED
);

    // map a fuse setting to the boot section start
    function automatic logic [15:0] boot_base(input logic [1:0] size);
        logic [15:0] b;
        b = BOOT_BASE_512;
        if (size == BOOT_SIZE_2K) begin
            b = BOOT_BASE_2K;
        end else if (size == BOOT_SIZE_4K) begin
            b = BOOT_BASE_4K;
        end else if (size == BOOT_SIZE_1K) begin
            b = BOOT_BASE_1K;
        end
        return b;
    endfunction : boot_base

    // register hit on the low address byte
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : hit

    logic rst_q1;
    logic rst_n;

    // reset release through two flops
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // fuse and lock straps, synchronised
    logic [4:0] strap_s1;
    logic [4:0] strap_s2;
    logic [1:0] boot_size;
    logic boot_reset_prog;
    logic app_lock;
    logic boot_lock;

    always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            strap_s1 <= 5'h00;
            strap_s2 <= 5'h00;
        end else begin
            strap_s1 <= {I_BOOT_SIZE_FUSES, ~I_BOOT_RESET_FUSE,
                         I_APP_SIDE_BOOT_LOCK, I_BOOT_SIDE_BOOT_LOCK};
            strap_s2 <= strap_s1;
        end
    end

    assign boot_size = strap_s2[4:3];
    assign boot_reset_prog = strap_s2[2];
    assign app_lock = strap_s2[1];
    assign boot_lock = strap_s2[0];

    // ---- bus slave: zero-wait writes, one-wait reads ----
    logic aphase;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr_q;
    logic hready_out;
    logic [31:0] hrdata;
    logic next_wr_pend;
    logic next_rd_pend;
    logic [7:0] next_addr;
    logic next_hready;
    logic [31:0] next_hrdata;
    logic [7:0] wbyte;
    logic [7:0] rbyte;

    // register state
    logic table_sel;
    logic change_en;
    logic [2:0] win_cnt;
    eivp_seq_e state;
    logic [3:0] sense;
    logic [1:0] ext_mask;
    logic [2:0] pc_enable;
    logic [2:0] pc_flag;
    logic [7:0] pc_mask_low;
    logic [6:0] pc_mask_mid;
    logic [7:0] pc_mask_high;
    logic next_table_sel;
    logic next_change_en;
    logic [2:0] next_win_cnt;
    eivp_seq_e next_state;
    logic [3:0] next_sense;
    logic [1:0] next_ext_mask;
    logic [2:0] next_pc_enable;
    logic [2:0] next_pc_flag;
    logic [7:0] next_pc_mask_low;
    logic [6:0] next_pc_mask_mid;
    logic [7:0] next_pc_mask_high;

    // interrupt side
    logic [1:0] ext_flag;
    logic [1:0] ext_req;
    logic [1:0] ext_clear;
    logic [4:0] ack_clear;
    logic [23:0] pc_s1;
    logic [23:0] pc_s2;
    logic [23:0] pc_prev;
    logic [23:0] pc_toggle;
    logic [2:0] pc_hit;
    logic [2:0] pc_w1c;
    logic [4:0] pending;
    logic [4:0] enables;
    logic blocked_next;
    logic lock_mute;
    logic [4:0] next_irq_req;
    logic [15:0] next_irq_vector;
    logic [15:0] next_vector_base;
    logic [15:0] next_reset_addr;
    logic wr_vec;

    assign aphase = I_HSEL & I_HTRANS[1] & I_HREADY;
    assign wbyte = I_HWDATA[7:0];

    // read mux, unused bits read zero
    always_comb begin
        rbyte = 8'h00;
        if (hit(addr_q, OFS_VEC_CTRL)) begin
            rbyte = {6'h00, table_sel, change_en};
        end else if (hit(addr_q, OFS_SENSE)) begin
            rbyte = {4'h0, sense};
        end else if (hit(addr_q, OFS_EXT_MASK)) begin
            rbyte = {6'h00, ext_mask};
        end else if (hit(addr_q, OFS_EXT_FLAG)) begin
            rbyte = {6'h00, ext_flag};
        end else if (hit(addr_q, OFS_PC_ENABLE)) begin
            rbyte = {5'h00, pc_enable};
        end else if (hit(addr_q, OFS_PC_FLAG)) begin
            rbyte = {5'h00, pc_flag};
        end else if (hit(addr_q, OFS_PC_MASK_LOW)) begin
            rbyte = pc_mask_low;
        end else if (hit(addr_q, OFS_PC_MASK_MID)) begin
            rbyte = {1'b0, pc_mask_mid};
        end else if (hit(addr_q, OFS_PC_MASK_HIGH)) begin
            rbyte = pc_mask_high;
        end
    end

    // bus phase tracking
    always_comb begin
        next_wr_pend = aphase & I_HWRITE;
        next_rd_pend = aphase & ~I_HWRITE;
        next_addr = aphase ? I_HADDR[7:0] : addr_q;
        next_hready = ~(aphase & ~I_HWRITE);
        next_hrdata = rd_pend ? {24'h000000, rbyte} : hrdata;
    end

    always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 8'h00;
            hready_out <= 1'b1;
            hrdata <= 32'h00000000;
        end else begin
            wr_pend <= next_wr_pend;
            rd_pend <= next_rd_pend;
            addr_q <= next_addr;
            hready_out <= next_hready;
            hrdata <= next_hrdata;
        end
    end

    assign wr_vec = wr_pend & hit(addr_q, OFS_VEC_CTRL);

    // protected vector select sequence
    always_comb begin
        next_table_sel = table_sel;
        next_change_en = change_en;
        next_win_cnt = win_cnt;
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (wr_vec && wbyte[POS_CHANGE_EN]) begin
                    next_change_en = 1'b1;
                    next_win_cnt = CHANGE_WINDOW_CYCLES;
                    next_state = ST_WINDOW;
                end
            end
            ST_WINDOW: begin
                if (wr_vec && wbyte[POS_CHANGE_EN]) begin
                    next_win_cnt = CHANGE_WINDOW_CYCLES;
                end else if (wr_vec) begin
                    next_table_sel = wbyte[POS_TABLE_SEL];
                    next_change_en = 1'b0;
                    next_state = ST_TRAIL;
                end else if (win_cnt == 3'h1) begin
                    next_change_en = 1'b0;
                    next_state = ST_IDLE;
                end else begin
                    next_win_cnt = win_cnt - 3'h1;
                end
            end
            ST_TRAIL: begin
                if (wr_vec && wbyte[POS_CHANGE_EN]) begin
                    next_change_en = 1'b1;
                    next_win_cnt = CHANGE_WINDOW_CYCLES;
                    next_state = ST_WINDOW;
                end else if (I_INSTR_DONE) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_change_en = 1'b0;
                next_state = ST_IDLE;
            end
        endcase
    end

    // plain control registers and pin-change flags
    always_comb begin
        next_sense = sense;
        next_ext_mask = ext_mask;
        next_pc_enable = pc_enable;
        next_pc_mask_low = pc_mask_low;
        next_pc_mask_mid = pc_mask_mid;
        next_pc_mask_high = pc_mask_high;
        pc_w1c = 3'h0;
        if (wr_pend) begin
            if (hit(addr_q, OFS_SENSE)) begin
                next_sense = wbyte[3:0];
            end else if (hit(addr_q, OFS_EXT_MASK)) begin
                next_ext_mask = wbyte[1:0];
            end else if (hit(addr_q, OFS_PC_ENABLE)) begin
                next_pc_enable = wbyte[2:0];
            end else if (hit(addr_q, OFS_PC_FLAG)) begin
                pc_w1c = wbyte[2:0];
            end else if (hit(addr_q, OFS_PC_MASK_LOW)) begin
                next_pc_mask_low = wbyte;
            end else if (hit(addr_q, OFS_PC_MASK_MID)) begin
                next_pc_mask_mid = wbyte[6:0];
            end else if (hit(addr_q, OFS_PC_MASK_HIGH)) begin
                next_pc_mask_high = wbyte;
            end
        end
        for (int g = 0; g < 3; g++) begin
            next_pc_flag[g] = pc_flag[g];
            if (pc_w1c[g] || ack_clear[IDX_PC_LOW + g]) begin
                next_pc_flag[g] = 1'b0;
            end
            if (pc_hit[g]) begin
                next_pc_flag[g] = 1'b1;
            end
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            table_sel <= 1'b0;
            change_en <= 1'b0;
            win_cnt <= 3'h0;
            state <= ST_IDLE;
            sense <= RST_SENSE;
            ext_mask <= RST_EXT_MASK;
            pc_enable <= RST_PC_ENABLE;
            pc_flag <= RST_PC_FLAG;
            pc_mask_low <= RST_PC_MASK_LOW;
            pc_mask_mid <= RST_PC_MASK_MID;
            pc_mask_high <= RST_PC_MASK_HIGH;
        end else begin
            table_sel <= next_table_sel;
            change_en <= next_change_en;
            win_cnt <= next_win_cnt;
            state <= next_state;
            sense <= next_sense;
            ext_mask <= next_ext_mask;
            pc_enable <= next_pc_enable;
            pc_flag <= next_pc_flag;
            pc_mask_low <= next_pc_mask_low;
            pc_mask_mid <= next_pc_mask_mid;
            pc_mask_high <= next_pc_mask_high;
        end
    end

    // handler entry clears the acknowledged slot
    assign ack_clear = I_IRQ_ACK ? 5'(5'h01 << I_ACK_INDEX) : 5'h00;
    assign ext_clear[0] = ack_clear[IDX_EXT_A]
                        | (wr_pend & hit(addr_q, OFS_EXT_FLAG) & wbyte[0]);
    assign ext_clear[1] = ack_clear[IDX_EXT_B]
                        | (wr_pend & hit(addr_q, OFS_EXT_FLAG) & wbyte[1]);

    // one sense block per dedicated pin, pin level read whatever its direction
    eivp_ext_sense u_sense_a (
        .i_clk(I_CLK_SYS),
        .i_rst_n(rst_n),
        .i_pin(I_EXT_IRQ_PIN_A),
        .i_sense(sense[POS_SENSE_A +: 2]),
        .i_clear(ext_clear[0]),
        .o_request(ext_req[0]),
        .o_flag(ext_flag[0])
    );

    eivp_ext_sense u_sense_b (
        .i_clk(I_CLK_SYS),
        .i_rst_n(rst_n),
        .i_pin(I_EXT_IRQ_PIN_B),
        .i_sense(sense[POS_SENSE_B +: 2]),
        .i_clear(ext_clear[1]),
        .o_request(ext_req[1]),
        .o_flag(ext_flag[1])
    );

    // pin-change inputs: two sync stages then a previous sample
    always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            pc_s1 <= 24'h000000;
            pc_s2 <= 24'h000000;
            pc_prev <= 24'h000000;
        end else begin
            pc_s1 <= I_PIN_CHANGE_INPUTS;
            pc_s2 <= pc_s1;
            pc_prev <= pc_s2;
        end
    end

    // any enabled toggle in a group raises its flag
    assign pc_toggle = pc_s2 ^ pc_prev;
    assign pc_hit[0] = |(pc_toggle[7:0] & pc_mask_low);
    assign pc_hit[1] = |(pc_toggle[14:8] & pc_mask_mid);
    assign pc_hit[2] = |(pc_toggle[23:16] & pc_mask_high);

    // request gating toward the core
    always_comb begin
        pending = {pc_flag, ext_req};
        enables = {pc_enable, ext_mask};
        blocked_next = (next_state != ST_IDLE);
        lock_mute = (next_table_sel & app_lock & ~I_EXEC_IN_BOOT)
                  | (~next_table_sel & boot_lock & I_EXEC_IN_BOOT);
        // global enable is read only, never written here
        next_irq_req = pending & enables
                     & {NUM_IRQ{I_GLOBAL_IE & ~blocked_next & ~lock_mute}};
        next_vector_base = next_table_sel ? boot_base(boot_size) : APP_VECTOR_BASE;
        next_reset_addr = boot_reset_prog ? boot_base(boot_size) : APP_VECTOR_BASE;
        next_irq_vector = next_vector_base;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (next_irq_req[i]) begin
                next_irq_vector = next_vector_base + VEC_SLOT_WORDS * 16'(i + 1);
            end
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            O_IRQ_REQ <= 5'h00;
            O_IRQ_VECTOR <= APP_VECTOR_BASE;
            O_VECTOR_BASE <= APP_VECTOR_BASE;
            O_RESET_ADDR <= APP_VECTOR_BASE;
            O_IRQ_BLOCKED <= 1'b0;
        end else begin
            O_IRQ_REQ <= next_irq_req;
            O_IRQ_VECTOR <= next_irq_vector;
            O_VECTOR_BASE <= next_vector_base;
            O_RESET_ADDR <= next_reset_addr;
            O_IRQ_BLOCKED <= blocked_next;
        end
    end

    assign O_HRDATA = hrdata;
    assign O_HREADYOUT = hready_out;
    assign O_HRESP = 1'b0;

endmodule : eivp_top

// File: eivp_pkg.sv
package eivp_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_VEC_CTRL = 8'h00;
    localparam logic [7:0] OFS_SENSE = 8'h04;
    localparam logic [7:0] OFS_EXT_MASK = 8'h08;
    localparam logic [7:0] OFS_EXT_FLAG = 8'h0C;
    localparam logic [7:0] OFS_PC_ENABLE = 8'h10;
    localparam logic [7:0] OFS_PC_FLAG = 8'h14;
    localparam logic [7:0] OFS_PC_MASK_LOW = 8'h18;
    localparam logic [7:0] OFS_PC_MASK_MID = 8'h1C;
    localparam logic [7:0] OFS_PC_MASK_HIGH = 8'h20;

    // field positions
    localparam int POS_CHANGE_EN = 0;
    localparam int POS_TABLE_SEL = 1;
    localparam int POS_SENSE_A = 0;
    localparam int POS_SENSE_B = 2;

    // reset values
    localparam logic [3:0] RST_SENSE = 4'h0;
    localparam logic [1:0] RST_EXT_MASK = 2'h0;
    localparam logic [2:0] RST_PC_ENABLE = 3'h0;
    localparam logic [2:0] RST_PC_FLAG = 3'h0;
    localparam logic [7:0] RST_PC_MASK_LOW = 8'h00;
    localparam logic [6:0] RST_PC_MASK_MID = 7'h00;
    localparam logic [7:0] RST_PC_MASK_HIGH = 8'h00;

    // protected change window, in system clock cycles
    localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;

    // program memory word addresses
    localparam logic [15:0] APP_VECTOR_BASE = 16'h0000;
    localparam logic [15:0] VEC_SLOT_WORDS = 16'h0002;
    localparam logic [1:0] BOOT_SIZE_2K = 2'h1;
    localparam logic [15:0] BOOT_BASE_2K = 16'h3C00;
    localparam logic [15:0] BOOT_BASE_4K = 16'h3800;
    localparam logic [15:0] BOOT_BASE_1K = 16'h3E00;
    localparam logic [15:0] BOOT_BASE_512 = 16'h3F00;
    localparam logic [1:0] BOOT_SIZE_4K = 2'h0;
    localparam logic [1:0] BOOT_SIZE_1K = 2'h2;

    // interrupt slot indices, lowest index wins
    localparam int NUM_IRQ = 5;
    localparam int IDX_EXT_A = 0;
    localparam int IDX_EXT_B = 1;
    localparam int IDX_PC_LOW = 2;

    typedef enum logic [1:0] {
        SENSE_LOW = 2'h0,
        SENSE_ANY = 2'h1,
        SENSE_FALL = 2'h2,
        SENSE_RISE = 2'h3
    } eivp_sense_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WINDOW = 3'h2,
        ST_TRAIL = 3'h4
    } eivp_seq_e;

endpackage : eivp_pkg

// File: eivp_ext_sense.sv
`timescale 1ns/1ps
module eivp_ext_sense
    import eivp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_pin,
    input wire logic [1:0] i_sense,
    input wire logic i_clear,
    output logic o_request,
    output logic o_flag
);

    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic flag;
    logic next_flag;
    logic hit;

    // edge select and sticky flag, set beats clear
    always_comb begin
        hit = 1'b0;
        case (eivp_sense_e'(i_sense))
            SENSE_ANY: hit = pin_s2 ^ pin_prev;
            SENSE_FALL: hit = ~pin_s2 & pin_prev;
            SENSE_RISE: hit = pin_s2 & ~pin_prev;
            default: hit = 1'b0;
        endcase
        next_flag = flag;
        if (i_clear) begin
            next_flag = 1'b0;
        end
        if (hit) begin
            next_flag = 1'b1;
        end
        if (eivp_sense_e'(i_sense) == SENSE_LOW) begin
            next_flag = 1'b0;
        end
    end

    // pin sampled twice before the edge compare
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
            pin_prev <= 1'b1;
            flag <= 1'b0;
        end else begin
            pin_s1 <= i_pin;
            pin_s2 <= pin_s1;
            pin_prev <= pin_s2;
            flag <= next_flag;
        end
    end

    // low level requests while held low, else the flag
    assign o_request = (eivp_sense_e'(i_sense) == SENSE_LOW) ? ~pin_s2 : flag;
    assign o_flag = flag;

endmodule : eivp_ext_sense

// File: eivp_asserts.sv
`timescale 1ns/1ps
module eivp_asserts
    import eivp_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic I_HSEL,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic I_HREADY,
    input wire logic I_GLOBAL_IE,
    input wire logic [1:0] I_BOOT_SIZE_FUSES,
    input wire logic [31:0] O_HRDATA,
    input wire logic O_HREADYOUT,
    input wire logic O_HRESP,
    input wire logic [4:0] O_IRQ_REQ,
    input wire logic [15:0] O_IRQ_VECTOR,
    input wire logic [15:0] O_VECTOR_BASE,
    input wire logic O_IRQ_BLOCKED
);
    logic [15:0] bb;
    logic tk;
    // boot base picked by the size straps
    always_comb begin
        case (I_BOOT_SIZE_FUSES)
            BOOT_SIZE_4K: bb = BOOT_BASE_4K;
            BOOT_SIZE_2K: bb = BOOT_BASE_2K;
            BOOT_SIZE_1K: bb = BOOT_BASE_1K;
            default: bb = BOOT_BASE_512;
        endcase
    end
    assign tk = I_HSEL && I_HTRANS[1] && I_HREADY;
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    property p_okay; O_HRESP == 1'b0; endproperty
    property p_rd_wait; tk && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT; endproperty
    property p_wr_now; tk && I_HWRITE |=> O_HREADYOUT; endproperty
    // straps pass two sync flops and the output flop, so compare three edges back
    property p_base;
        O_VECTOR_BASE == APP_VECTOR_BASE || O_VECTOR_BASE == $past(bb, 3);
    endproperty
    property p_vec;
        O_IRQ_REQ[0] && $past(O_IRQ_REQ[0]) |-> O_IRQ_VECTOR == O_VECTOR_BASE + VEC_SLOT_WORDS;
    endproperty
    property p_blk; O_IRQ_BLOCKED && $past(O_IRQ_BLOCKED) |-> O_IRQ_REQ == 5'h00; endproperty
    property p_ie; !I_GLOBAL_IE && $past(!I_GLOBAL_IE) |-> O_IRQ_REQ == 5'h00; endproperty
    property p_rdata; O_HRDATA[31:8] == 24'h000000; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    a_rd_wait: assert property (p_rd_wait) else $error("read wait shape wrong");
    a_wr_now: assert property (p_wr_now) else $error("write not zero wait");
    a_base: assert property (p_base) else $error("vector base illegal");
    a_vec: assert property (p_vec) else $error("vector slot wrong");
    a_blk: assert property (p_blk) else $error("request while blocked");
    a_ie: assert property (p_ie) else $error("request without global enable");
    a_rdata: assert property (p_rdata) else $error("upper read bits set");
    c_blk: cover property (O_IRQ_BLOCKED);
    c_boot: cover property (O_VECTOR_BASE == bb);
    c_pc: cover property (O_IRQ_REQ[4]);
endmodule : eivp_asserts
bind eivp_top eivp_asserts chk_u (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_HSEL(I_HSEL),
    .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .I_GLOBAL_IE(I_GLOBAL_IE),
    .I_BOOT_SIZE_FUSES(I_BOOT_SIZE_FUSES), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT),
    .O_HRESP(O_HRESP), .O_IRQ_REQ(O_IRQ_REQ), .O_IRQ_VECTOR(O_IRQ_VECTOR),
    .O_VECTOR_BASE(O_VECTOR_BASE), .O_IRQ_BLOCKED(O_IRQ_BLOCKED));

// File: eivp_core_model.sv
`timescale 1ns/1ps
module eivp_core_model
    import eivp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ack_en,
    input wire logic [4:0] i_irq_req,
    output logic o_instr_done,
    output logic o_irq_ack,
    output logic [2:0] o_ack_index
);
    logic [1:0] cnt;
    logic [2:0] low;
    // lowest pending slot wins
    always_comb begin
        low = 3'h0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (i_irq_req[i]) begin
                low = 3'(i);
            end
        end
    end
    // one instruction ends every fourth cycle; handler entry when allowed
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 2'h0;
            o_instr_done <= 1'b0;
            o_irq_ack <= 1'b0;
            o_ack_index <= 3'h7;
        end else begin
            cnt <= cnt + 2'h1;
            o_instr_done <= (cnt == 2'h3);
            o_irq_ack <= i_ack_en && (i_irq_req != 5'h00) && !o_irq_ack;
            o_ack_index <= (i_ack_en && i_irq_req != 5'h00) ? low : ~o_ack_index;
        end
    end
endmodule : eivp_core_model

// File: ext_irq_and_vector_placement_bench.sv
`timescale 1ns/1ps
module ext_irq_and_vector_placement_bench;
    import eivp_pkg::*;
    logic clk, rst_n, hsel, hwrite, rdy, resp, gie, boot, alock, block, pa, pb, ack_en;
    logic done, ack, blocked, brf;
    logic [1:0] htrans, bsz;
    logic [2:0] aidx;
    logic [4:0] req;
    logic [7:0] ofs [9];
    logic [15:0] vec, base, raddr;
    logic [23:0] pc;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    int n_errors, total_checks;
    eivp_top dut_u (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(rdy),
        .O_HRDATA(hrdata), .O_HREADYOUT(rdy), .O_HRESP(resp), .I_GLOBAL_IE(gie),
        .I_INSTR_DONE(done), .I_EXEC_IN_BOOT(boot), .I_IRQ_ACK(ack), .I_ACK_INDEX(aidx),
        .I_BOOT_SIZE_FUSES(bsz), .I_BOOT_RESET_FUSE(brf),
        .I_APP_SIDE_BOOT_LOCK(alock), .I_BOOT_SIDE_BOOT_LOCK(block), .I_EXT_IRQ_PIN_A(pa),
        .I_EXT_IRQ_PIN_B(pb), .I_PIN_CHANGE_INPUTS(pc), .O_IRQ_REQ(req), .O_IRQ_VECTOR(vec),
        .O_VECTOR_BASE(base), .O_RESET_ADDR(raddr), .O_IRQ_BLOCKED(blocked));
    eivp_core_model core_u (.i_clk(clk), .i_rst_n(rst_n), .i_ack_en(ack_en), .i_irq_req(req),
        .o_instr_done(done), .o_irq_ack(ack), .o_ack_index(aidx));
    // free running system clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // one single AHB transfer, waits on ready with a bound
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        n = 0;
        do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 40);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 80);
        if (n >= 80) begin
            n_errors++;
            $display("BAD %0t bus hang", $time);
            end_of_test();
        end else begin
            rdv = hrdata;
        end
    endtask : xfer
    task rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h00000000);
        chk(rdv, e);
    endtask : rd
    // main sequence
    initial begin
        ofs = '{OFS_VEC_CTRL, OFS_SENSE, OFS_EXT_MASK, OFS_EXT_FLAG, OFS_PC_ENABLE, OFS_PC_FLAG,
            OFS_PC_MASK_LOW, OFS_PC_MASK_MID, OFS_PC_MASK_HIGH};
        {n_errors, total_checks} = '0;
        {rst_n, hsel, hwrite, htrans, haddr, hwdata, boot, alock, block, ack_en, pc, brf} = '0;
        {gie, pa, pb} = 3'h7;
        bsz = BOOT_SIZE_2K;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        cyc(8);
        for (int i = 0; i < 9; i++) rd(ofs[i], 32'h00000000);
        xfer(1'b1, 8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h00000000);
        xfer(1'b1, OFS_SENSE, 32'h000000FF);
        rd(OFS_SENSE, 32'h0000000F);
        chk(raddr, BOOT_BASE_2K);
        $display("register test done");
        xfer(1'b1, OFS_VEC_CTRL, 32'h2);
        xfer(1'b1, OFS_VEC_CTRL, 32'h1);
        cyc(1);
        chk(blocked, 1'b1);
        chk(base, APP_VECTOR_BASE);
        cyc(6);
        chk(blocked, 1'b0);
        rd(OFS_VEC_CTRL, 32'h0);
        xfer(1'b1, OFS_VEC_CTRL, 32'h2);
        xfer(1'b1, OFS_VEC_CTRL, 32'h1);
        xfer(1'b1, OFS_VEC_CTRL, 32'h2);
        cyc(10);
        chk(base, BOOT_BASE_2K);
        chk(blocked, 1'b0);
        rd(OFS_VEC_CTRL, 32'h2);
        {bsz, brf} <= {BOOT_SIZE_4K, 1'b1};
        cyc(6);
        chk(base, BOOT_BASE_4K);
        chk(raddr, APP_VECTOR_BASE);
        bsz <= BOOT_SIZE_2K;
        cyc(6);
        $display("vector move test done");
        xfer(1'b1, OFS_EXT_MASK, 32'h3);
        for (int s = 0; s < 4; s++) begin
            xfer(1'b1, OFS_SENSE, s);
            xfer(1'b1, OFS_EXT_FLAG, 32'h3);
            pa <= 1'b0;
            cyc(8);
            chk(req[0], s != 3);
            if (s != 3) chk(vec, BOOT_BASE_2K + VEC_SLOT_WORDS);
            xfer(1'b1, OFS_EXT_FLAG, 32'h3);
            cyc(3);
            chk(req[0], s == 0);
            pa <= 1'b1;
            cyc(8);
            chk(req[0], s == 1 || s == 3);
        end
        xfer(1'b1, OFS_SENSE, 32'h8);
        xfer(1'b1, OFS_EXT_FLAG, 32'h3);
        gie <= 1'b0;
        pb <= 1'b0;
        cyc(8);
        chk(req, 5'h00);
        gie <= 1'b1;
        cyc(3);
        chk(req, 5'h02);
        chk(vec, BOOT_BASE_2K + 16'h0004);
        alock <= 1'b1;
        cyc(8);
        chk(req, 5'h00);
        boot <= 1'b1;
        cyc(8);
        chk(req, 5'h02);
        xfer(1'b1, OFS_VEC_CTRL, 32'h1);
        xfer(1'b1, OFS_VEC_CTRL, 32'h0);
        block <= 1'b1;
        cyc(8);
        chk(req, 5'h00);
        block <= 1'b0;
        cyc(8);
        chk(req, 5'h02);
        alock <= 1'b0;
        ack_en <= 1'b1;
        cyc(8);
        rd(OFS_EXT_FLAG, 32'h0);
        ack_en <= 1'b0;
        $display("external pin test done");
        xfer(1'b1, OFS_PC_ENABLE, 32'h7);
        for (int g = 0; g < 3; g++) begin
            xfer(1'b1, ofs[6 + g], 32'h1);
            pc[g * 8 + 1] <= 1'b1;
            cyc(8);
            chk(req, 5'h00);
            pc[g * 8] <= 1'b1;
            cyc(8);
            chk(req, 5'h04 << g);
            xfer(1'b1, ofs[6 + g], 32'h0);
            xfer(1'b1, OFS_PC_FLAG, 32'h7);
        end
        $display("pin change test done");
        end_of_test();
    end
endmodule : ext_irq_and_vector_placement_bench
